//--- rtl/twes_mem.sv
// Storage array of the serial memory: one write port, one registered read port.
// Assumes the owner holds the read address steady while it waits for data.
`timescale 1ns/1ps

module twes_mem #(
   parameter int AW = 8,
   parameter int DW = 8
)(
   input  wire logic          clk_sys,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // No reset: the array models nonvolatile content
   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end

endmodule

//--- rtl/twes_pkg.sv
// Constants, state encoding and timing for the two-wire serial memory slave.
// Assumes a 200 MHz system clock that oversamples the serial clock and data pins.
//
// What this block does
// RQ1: Data line changes only while serial clock is low, except start and stop.
// RQ2: Start is data falling with clock high; everything before a start is ignored.
// RQ3: Stop is data rising with clock high; it ends every transfer, read ends in standby.
// RQ4: Master issues stop only after the transmitter released the data line.
// RQ5: Transmitter releases data after eight bits; receiver pulls low through ninth clock.
// RQ6: After a start, acknowledge only when the slave address matches our own.
// RQ7: Read: send eight bits, release, sample acknowledge; continue on ack, stop on none.
// RQ8: After a missing read acknowledge the master must send a stop.
// RQ9: Upper four slave address bits must equal the fixed device-type constant.
// RQ10: Next three slave address bits must match the three select pins.
// RQ11: Last slave address bit: one means read, zero means write.
// RQ12: When addressed for write, acknowledge every following received byte.
// RQ13: Write carries an eight-bit word address, acknowledged, then acknowledged data.
// RQ14: A stop after write data starts the self-timed programming cycle.
// RQ15: During programming the device ignores inputs and answers no request.
// RQ16: Page write: master sends up to three more bytes, four in total, each acknowledged.
// RQ17: Per written byte only the two low address bits increment; page wraps.
// RQ18: Acknowledge polling: no ack while programming, ack once it has finished.
// RQ19: Master ends a read by stop in ninth clock, or high ninth clock then stop.
// RQ20: Writes happen only while the write-inhibit input is low.
// RQ21: The master always starts transfers and supplies the clock; device is slave.
// RQ22: Address counter holds last address plus one; plain read uses it.
// RQ23: Reads increment all eight address bits and roll over from top to zero.
// RQ24: Programming time is a parameterised cycle count; busy gates acknowledges.

package twes_pkg;

   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int         ADDR_W     = 8;
   localparam int         DATA_W     = 8;
   localparam int         PAGE_W     = 2;
   localparam int         PAGE_BYTES = 4;
   localparam logic [3:0] BYTE_BITS  = 4'h8;
   localparam logic [2:0] COMMIT_END = 3'h4;

   // ----------------------------------------------------------------
   // Slave address layout and reset values
   // ----------------------------------------------------------------
   localparam int         SA_TYPE_LSB = 4;
   localparam int         SA_SEL_LSB  = 1;
   localparam int         SA_RW_BIT   = 0;
   localparam logic [3:0] DEV_TYPE_DEF = 4'h6;   // Arbitrary value
   localparam logic [7:0] ADDR_RST    = 8'h00;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ         = 200;
   localparam int PROG_TIME_US    = 5000;
   localparam int PROG_CYCLES_DEF = PROG_TIME_US * CLK_MHZ;

   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE     = 4'h0,
      ST_DEV      = 4'h1,
      ST_DEV_ACK  = 4'h2,
      ST_WORD     = 4'h3,
      ST_WORD_ACK = 4'h4,
      ST_WR       = 4'h5,
      ST_WR_ACK   = 4'h6,
      ST_RD       = 4'h7,
      ST_RD_ACK   = 4'h8,
      ST_PROG     = 4'h9
   } twes_state_e;

endpackage

//--- rtl/twes_top.sv
// Two-wire serial memory slave: start/stop, addressing, page write, reads.
// Assumes scl and sda arrive asynchronously and are far slower than clk_sys.
`timescale 1ns/1ps

module twes_top
   import twes_pkg::*;
#(
   parameter int         PROG_CYCLES = PROG_CYCLES_DEF,
   parameter logic [3:0] DEV_TYPE    = DEV_TYPE_DEF     // Arbitrary value
)(
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic scl_pin,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe,
   input  wire logic select_pin_bit0,
   input  wire logic select_pin_bit1,
   input  wire logic select_pin_bit2,
   input  wire logic write_inhibit_input,
   output logic      prog_busy
);

   localparam int PW = $clog2(PROG_CYCLES + 1);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [5:0] sync1;
   logic [5:0] sync2;
   logic       scl_d;
   logic       sda_d;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sync1 <= 6'h3F;
         sync2 <= 6'h3F;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         sync1 <= {write_inhibit_input, select_pin_bit2, select_pin_bit1,
                   select_pin_bit0, sda_in, scl_pin};
         sync2 <= sync1;
         scl_d <= sync2[0];
         sda_d <= sync2[1];
      end
   end

   wire       scl_s     = sync2[0];
   wire       sda_s     = sync2[1];
   wire [2:0] sel_s     = sync2[4:2];
   wire       inhibit_s = sync2[5];

   wire scl_rise  = scl_s & ~scl_d;
   wire scl_fall  = ~scl_s & scl_d;
   // Both conditions need the clock high on both samples; data edge is the mark
   wire start_det = scl_s & scl_d & sda_d & ~sda_s;                            // RQ2
   wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;                            // RQ3

   // ----------------------------------------------------------------
   // State and datapath registers
   // ----------------------------------------------------------------
   twes_state_e        state;
   twes_state_e        next_state;
   logic [3:0]         bit_cnt;
   logic [7:0]         shreg;
   logic [7:0]         tx;
   logic [ADDR_W-1:0]  word_addr;
   logic [DATA_W-1:0]  page_data [0:PAGE_BYTES-1];
   logic [PAGE_BYTES-1:0] page_valid;
   logic               rd_mode;
   logic               master_ack;
   logic [PW-1:0]      prog_cnt;
   logic [2:0]         commit_idx;
   logic               next_sda_oe;
   logic [DATA_W-1:0]  mem_rdata;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire addr_hit  = (shreg[7:SA_TYPE_LSB] == DEV_TYPE) &                       // RQ9
                    (shreg[SA_TYPE_LSB-1:SA_SEL_LSB] == sel_s);               // RQ10
   wire in_rx     = (state == ST_DEV) | (state == ST_WORD) | (state == ST_WR);
   wire in_bits   = in_rx | (state == ST_RD);
   // Ack states still hold eight in the counter; the ninth fall must not pass as a byte
   wire byte_done = scl_fall & in_bits & (bit_cnt == BYTE_BITS);              // RQ5
   wire in_write  = (state == ST_WR) | (state == ST_WR_ACK);
   // Inhibit high blocks the programming cycle; bytes are still acknowledged
   wire prog_go   = in_write & (|page_valid) & ~inhibit_s;                    // RQ14 RQ20
   wire prog_done = (prog_cnt == '0);
   wire enter_rd  = scl_fall & (((state == ST_DEV_ACK) & rd_mode) |
                                ((state == ST_RD_ACK) & master_ack));         // RQ7
   wire wr_byte   = (state == ST_WR) & byte_done;
   wire mem_we    = (state == ST_PROG) & (commit_idx < COMMIT_END) &
                    page_valid[commit_idx[PAGE_W-1:0]];
   wire [ADDR_W-1:0] mem_waddr = {word_addr[ADDR_W-1:PAGE_W], commit_idx[PAGE_W-1:0]};
   wire [ADDR_W-1:0] page_next = {word_addr[ADDR_W-1:PAGE_W],
                                  word_addr[PAGE_W-1:0] + 2'h1};              // RQ17

   // ----------------------------------------------------------------
   // State transitions
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      if (state == ST_PROG) begin
         // Starts and address bytes are not seen at all while busy
         if (prog_done) begin
            next_state = ST_IDLE;                                              // RQ15 RQ18
         end
      end else if (stop_det) begin
         next_state = prog_go ? ST_PROG : ST_IDLE;                             // RQ3 RQ14
      end else if (start_det) begin
         next_state = ST_DEV;                                                  // RQ2
      end else begin
         unique case (state)
            ST_IDLE: begin
               next_state = ST_IDLE;
            end
            ST_DEV: begin
               if (byte_done) next_state = addr_hit ? ST_DEV_ACK : ST_IDLE;    // RQ6
            end
            ST_DEV_ACK: begin
               if (scl_fall) next_state = rd_mode ? ST_RD : ST_WORD;           // RQ11
            end
            ST_WORD: begin
               if (byte_done) next_state = ST_WORD_ACK;                        // RQ13
            end
            ST_WORD_ACK: begin
               if (scl_fall) next_state = ST_WR;
            end
            ST_WR: begin
               if (byte_done) next_state = ST_WR_ACK;                          // RQ12
            end
            ST_WR_ACK: begin
               if (scl_fall) next_state = ST_WR;
            end
            ST_RD: begin
               if (byte_done) next_state = ST_RD_ACK;
            end
            ST_RD_ACK: begin
               if (scl_fall) next_state = master_ack ? ST_RD : ST_IDLE;        // RQ7
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Data line drive
   // ----------------------------------------------------------------
   always_comb begin
      next_sda_oe = sda_oe;
      if (state == ST_PROG || stop_det || start_det) begin
         next_sda_oe = 1'b0;                                                   // RQ15
      end else if (byte_done) begin
         next_sda_oe = (state == ST_DEV) ? addr_hit : in_rx;                   // RQ5 RQ6 RQ12
      end else if (enter_rd) begin
         next_sda_oe = ~mem_rdata[7];                                          // RQ7
      end else if (scl_fall && state == ST_RD) begin
         next_sda_oe = ~tx[6];                                                 // RQ1
      end else if (scl_fall) begin
         next_sda_oe = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state   <= ST_IDLE;
         sda_oe  <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         state   <= next_state;
         sda_oe  <= next_sda_oe;
         sda_out <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Bit counter, shifters and acknowledge sample
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bit_cnt    <= 4'h0;
         shreg      <= 8'h00;
         tx         <= 8'h00;
         rd_mode    <= 1'b0;
         master_ack <= 1'b0;
      end else begin
         if (start_det || (scl_fall && !in_bits)) begin
            bit_cnt <= 4'h0;
         end else if (scl_rise && in_bits) begin
            bit_cnt <= bit_cnt + 4'h1;
         end
         if (scl_rise && in_rx) begin
            shreg <= {shreg[6:0], sda_s};
         end
         if (byte_done && state == ST_DEV) begin
            rd_mode <= shreg[SA_RW_BIT];                                       // RQ11
         end
         if (enter_rd) begin
            tx <= mem_rdata;
         end else if (scl_fall && state == ST_RD) begin
            tx <= {tx[6:0], 1'b0};
         end
         if (scl_rise && state == ST_RD_ACK) begin
            master_ack <= ~sda_s;                                              // RQ7
         end
      end
   end

   // ----------------------------------------------------------------
   // Address counter and page buffer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         word_addr  <= ADDR_RST;
         page_valid <= '0;
      end else begin
         if (byte_done && state == ST_WORD) begin
            word_addr <= shreg;                                                // RQ13
         end else if (wr_byte) begin
            word_addr <= page_next;                                            // RQ17 RQ22
         end else if (enter_rd) begin
            word_addr <= word_addr + 8'h01;                                    // RQ22 RQ23
         end
         // A restart or a new word address abandons the unsent page
         if ((start_det && state != ST_PROG) || (byte_done && state == ST_WORD) ||
             (state == ST_PROG && prog_done)) begin
            page_valid <= '0;
         end else if (wr_byte) begin
            page_valid[word_addr[PAGE_W-1:0]] <= 1'b1;                         // RQ17
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (wr_byte) begin
         page_data[word_addr[PAGE_W-1:0]] <= shreg;
      end
   end

   // ----------------------------------------------------------------
   // Programming cycle
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prog_cnt   <= '0;
         commit_idx <= 3'h0;
         prog_busy  <= 1'b0;
      end else begin
         prog_busy <= (next_state == ST_PROG);                                 // RQ24
         if (state != ST_PROG) begin
            prog_cnt   <= PW'(PROG_CYCLES - 1);                                // RQ24
            commit_idx <= 3'h0;
         end else begin
            prog_cnt <= prog_cnt - PW'(1);
            if (commit_idx < COMMIT_END) begin
               commit_idx <= commit_idx + 3'h1;                                // RQ14
            end
         end
      end
   end

   twes_mem #(
      .AW (ADDR_W),
      .DW (DATA_W)
   ) u_mem (
      .clk_sys (clk_sys),
      .we      (mem_we),
      .waddr   (mem_waddr),
      .wdata   (page_data[commit_idx[PAGE_W-1:0]]),
      .raddr   (word_addr),
      .rdata   (mem_rdata)
   );

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   start_enters_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ2
      start_det && state != ST_PROG && !stop_det |=> state == ST_DEV)
      else $error("start did not open address phase");

   busy_silent_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ15
      state == ST_PROG |=> !sda_oe)
      else $error("data line driven while programming");

   addr_match_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ6
      state == ST_DEV && byte_done && !stop_det && !start_det |=> sda_oe == $past(addr_hit))
      else $error("address acknowledge disagrees with compare");

   wr_byte_ack_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ12
      wr_byte && !stop_det && !start_det |=> sda_oe ##1 sda_oe)
      else $error("write byte not acknowledged");

   stop_prog_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ14
      stop_det && state == ST_WR && |page_valid && !inhibit_s |=> state == ST_PROG)
      else $error("stop after data did not start programming");

   inhibit_block_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ20
      state != ST_PROG && inhibit_s |=> state != ST_PROG && !mem_we)
      else $error("write performed while inhibited");

   page_wrap_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ17
      wr_byte |=> word_addr[7:2] == $past(word_addr[7:2]) &&
                  word_addr[1:0] == $past(word_addr[1:0]) + 2'h1)
      else $error("page address did not wrap in low bits");

   rd_incr_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ23
      enter_rd && state != ST_PROG && !stop_det && !start_det |=>
         word_addr == $past(word_addr) + 8'h01)
      else $error("read counter did not advance");

   rd_nack_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ7
      state == ST_RD_ACK && scl_fall && !master_ack && !stop_det && !start_det
         |=> state == ST_IDLE && !sda_oe)
      else $error("read continued without acknowledge");

   prog_len_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ24
      state == ST_PROG && prog_done |=> state == ST_IDLE ##1 !prog_busy)
      else $error("programming cycle did not end on count");

   oe_low_clk_a: assert property (@(posedge clk_sys) disable iff (rst) // RQ1
      $changed(sda_oe) |-> !scl_d || $past(start_det) || $past(stop_det))
      else $error("data drive changed while clock high");

   cover_prog_c: cover property (@(posedge clk_sys) disable iff (rst)
      state == ST_WR ##1 state == ST_PROG);
   cover_seq_rd_c: cover property (@(posedge clk_sys) disable iff (rst)
      state == ST_RD_ACK ##1 state == ST_RD);
   cover_miss_c: cover property (@(posedge clk_sys) disable iff (rst)
      state == ST_DEV && byte_done && !addr_hit);
   cover_page_c: cover property (@(posedge clk_sys) disable iff (rst)
      page_valid == 4'hF);

endmodule

//--- sim/twes_master.sv
// Bus master model for the serial memory slave: start, stop and byte transfers.
// Assumes the bench resolves the data wire with a pull-up and feeds it back as sda_wire.
`timescale 1ns/1ps

module twes_master (
   input  wire logic clk_sys,
   input  wire logic sda_wire,
   output logic      scl_pin,
   output logic      sda_low
);
   // ----------------------------------------------------------------
   // Idle bus: clock stands high, data released
   // ----------------------------------------------------------------
   initial begin
      scl_pin = 1'b1;
      sda_low = 1'b0;
   end

   // Quarter of the 80 ns serial period; every change lands just after a clk_sys edge
   task automatic q(input int n);
      repeat (n * 4) @(posedge clk_sys);
      #1;
   endtask

   // Clock low first, so a repeated start never passes as a stop
   task automatic start_cond();
      scl_pin = 1'b0;
      q(1);
      sda_low = 1'b0;
      q(1);
      scl_pin = 1'b1;
      q(2);
      sda_low = 1'b1;
      q(2);
   endtask

   task automatic stop_cond();
      scl_pin = 1'b0;
      q(1);
      sda_low = 1'b1;
      q(1);
      scl_pin = 1'b1;
      q(2);
      sda_low = 1'b0;
      q(2);
   endtask

   task automatic bit_io(input logic b, output logic seen);
      scl_pin = 1'b0;
      q(1);
      sda_low = ~b;
      q(1);
      scl_pin = 1'b1;
      q(1);
      seen = sda_wire;
      q(1);
   endtask

   // A one in tx or ack_in leaves the wire released to the other party
   task automatic byte_io(input logic [7:0] tx, input logic ack_in,
                          output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
      bit_io(ack_in, ack);
   endtask
endmodule

//--- sim/twes_tb_top.sv
// Self-checking bench for the serial memory slave with a behavioural bus master.
// Assumes the programming time is shortened by parameter so polling stays quick.
`timescale 1ns/1ps

module twes_tb_top;
   import twes_pkg::*;
   localparam int         PROG_N = 400;
   localparam logic [3:0] DT     = 4'h5;   // Arbitrary value
   typedef struct { logic [7:0] a; logic [7:0] d; } twes_row_s;

   logic       clk_sys, rst, scl_pin, sda_low, sda_out, sda_oe, prog_busy;
   logic       write_inhibit_input, ack;
   logic [2:0] sel_pins;
   logic [7:0] rx;
   int         failures, n_checks, n;
   wire        sda_wire = ~((sda_oe & ~sda_out) | sda_low);
   twes_row_s  rows [4] = '{'{8'h00, 8'hA5}, '{8'h01, 8'h3C}, '{8'hFF, 8'hC3},
                            '{8'h5A, 8'h0F}};

   twes_top #(.PROG_CYCLES(PROG_N), .DEV_TYPE(DT)) dut (
      .clk_sys(clk_sys), .rst(rst), .scl_pin(scl_pin), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe(sda_oe), .select_pin_bit0(sel_pins[0]),
      .select_pin_bit1(sel_pins[1]), .select_pin_bit2(sel_pins[2]),
      .write_inhibit_input(write_inhibit_input), .prog_busy(prog_busy));

   twes_master m (.clk_sys(clk_sys), .sda_wire(sda_wire), .scl_pin(scl_pin),
                  .sda_low(sda_low));

   // ----------------------------------------------------------------
   // Checking and bus helpers
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic send(input logic [7:0] b, input logic exp_ack, input string what);
      m.byte_io(b, 1'b1, rx, ack);
      chk(what, {7'h00, ack}, {7'h00, exp_ack});
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d [$]);
      m.start_cond();
      send({DT, sel_pins, 1'b0}, 1'b0, "write address ack");
      send(a, 1'b0, "word address ack");
      foreach (d[i]) send(d[i], 1'b0, "data ack");
      m.stop_cond();
   endtask

   // Busy left after the stop should be the programming count, less the cycles the stop condition runs on after detection
   task automatic wait_idle();
      n = 0;
      while (prog_busy !== 1'b0 && n < 2 * PROG_N) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk("busy length", {7'h00, n > PROG_N - 16 && n <= PROG_N}, 8'h01);
   endtask

   task automatic rd(input logic [7:0] a, input bit dummy, input logic [7:0] e [$]);
      if (dummy) begin
         m.start_cond();
         send({DT, sel_pins, 1'b0}, 1'b0, "dummy write ack");
         send(a, 1'b0, "dummy word ack");
      end
      m.start_cond();
      send({DT, sel_pins, 1'b1}, 1'b0, "read address ack");
      foreach (e[i]) begin
         m.byte_io(8'hFF, i == e.size() - 1, rx, ack);
         chk("read data", rx, e[i]);
      end
      chk("released after nack", {7'h00, sda_oe}, 8'h00);
      m.stop_cond();
   endtask

   // ----------------------------------------------------------------
   // Clock, watchdog and test sequence
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // Whole sequence needs well under 100 us; three times that means a hang
   initial begin
      #300000;
      failures++;
      stop_test();
   end

   initial begin
      rst = 1'b1;
      sel_pins = 3'b101;
      write_inhibit_input = 1'b0;
      failures = 0;
      n_checks = 0;
      repeat (10) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      chk("data drive after reset", {7'h00, sda_oe}, 8'h00);
      chk("busy after reset", {7'h00, prog_busy}, 8'h00);
      m.byte_io({DT, sel_pins, 1'b0}, 1'b1, rx, ack);
      chk("ack without start", {7'h00, ack}, 8'h01);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(rows[i].a, '{rows[i].d});
         chk("busy after stop", {7'h00, prog_busy}, 8'h01);
         wait_idle();
         rd(rows[i].a, 1'b1, '{rows[i].d});
      end
      $display("test rows done");
      rd(8'hFF, 1'b1, '{8'hC3, 8'hA5});
      rd(8'h00, 1'b0, '{8'h3C});
      $display("test rollover done");
      wr(8'h12, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66});
      wait_idle();
      rd(8'h00, 1'b0, '{8'h33});
      rd(8'h10, 1'b1, '{8'h33, 8'h44, 8'h55, 8'h66});
      $display("test page wrap done");
      wr(8'h20, '{8'h77});
      m.start_cond();
      send({DT, sel_pins, 1'b0}, 1'b1, "ack while busy");
      n = 0;
      do begin
         m.start_cond();
         m.byte_io({DT, sel_pins, 1'b0}, 1'b1, rx, ack);
         n++;
      end while (ack !== 1'b0 && n < 8);
      m.stop_cond();
      chk("ack after programming", {7'h00, ack}, 8'h00);
      rd(8'h20, 1'b1, '{8'h77});
      $display("test polling done");
      sel_pins = 3'b010;
      for (int k = 0; k < 4; k++) begin
         m.start_cond();
         send({DT, sel_pins, 1'b0} ^ (k == 3 ? 8'h80 : 8'h02 << k), 1'b1,
              "foreign address ack");
         m.stop_cond();
      end
      m.start_cond();
      send({DT, sel_pins, 1'b0}, 1'b0, "own address ack");
      m.stop_cond();
      $display("test address match done");
      write_inhibit_input = 1'b1;
      wr(8'h00, '{8'hEE});
      chk("busy while inhibited", {7'h00, prog_busy}, 8'h00);
      write_inhibit_input = 1'b0;
      rd(8'h00, 1'b1, '{8'hA5});
      $display("test inhibit done");
      // Reset in mid programming: outputs drop at once, counter returns to its reset value
      wr(8'h30, '{8'h99});
      chk("busy before reset", {7'h00, prog_busy}, 8'h01);
      rst = 1'b1;
      @(posedge clk_sys);
      #1;
      chk("busy in reset", {7'h00, prog_busy}, 8'h00);
      rst = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      chk("drive after mid reset", {7'h00, sda_oe}, 8'h00);
      rd(8'h00, 1'b0, '{8'hA5});
      $display("test mid reset done");
      stop_test();
   end
endmodule
